// ### inc/ive_pkg.sv
// package: constants and types for the interrupt vector entry logic
package ive_pkg;
  // vector entry address arithmetic
  localparam int unsigned PRIO_SHIFT = 5;
  localparam int unsigned ENTRY_WORDS = 8;
  localparam int unsigned PRIO_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 32;
  localparam int unsigned TABLE_ENTRIES = 256;
  // base register layout
  localparam logic [31:0] VTB_RESET = 32'h0000_0000;
  localparam logic [31:0] VTB_WRITE_MASK = 32'hffff_fffe;
  localparam logic [31:0] VTB_OVERLAP_MASK = 32'h0000_0380;
  localparam logic [7:0] PRIO_NONE = 8'h00;
  localparam logic [7:0] CUR_PRIO_RESET = 8'h00;
  localparam logic IE_RESET = 1'b0;
  // entry sequencer states
  typedef enum logic [1:0] {
    IVE_IDLE,
    IVE_LOAD,
    IVE_RUN
  } ive_state_type;
endpackage

// ### design/ive_addr_calc.sv
// vector entry address former: priority shifted and ored with base
`timescale 1ns/1ns
module ive_addr_calc (
  input wire logic [7:0] prio,
  input wire logic [31:0] base,
  output logic [31:0] entry_addr
);
  // priority widened before the shift so no bits are lost
  logic [31:0] prio_wide;
  assign prio_wide = {24'h000000, prio};
  assign entry_addr = base | (prio_wide << ive_pkg::PRIO_SHIFT);
endmodule

// ### design/ive_core.sv
// interrupt entry and exit logic with vector table base register
`timescale 1ns/1ns
module ive_core (
  input wire logic clk,
  input wire logic rst_n,
  // pending request from the interrupt control unit
  input wire logic [7:0] pending_priority_number,
  // move_to_core_reg write of the base register
  input wire logic vtb_wr,
  input wire logic [31:0] vtb_wdata,
  input wire logic init_end_protect,
  // software writes of the interrupt_control_word fields
  input wire logic icw_wr,
  input wire logic icw_ie,
  input wire logic [7:0] icw_priority,
  // return_from_exception executed this cycle
  input wire logic return_from_exception,
  // pipeline may redirect now
  input wire logic pc_ready,
  output logic take_irq,
  output logic pc_load,
  output logic [31:0] pc_target,
  output logic [31:0] vector_table_base,
  output logic global_irq_enable,
  output logic [7:0] current_cpu_priority,
  output logic [7:0] saved_cpu_priority,
  output logic saved_irq_enable,
  output logic [7:0] serviced_priority,
  output logic base_overlap_warn
);
  //////////////////////////////////////////////////////////////////////
  // state and wires
  ive_pkg::ive_state_type state; // entry sequencer
  ive_pkg::ive_state_type next_state; // its next value
  logic [31:0] entry_addr; // combinational entry address
  logic [31:0] held_addr; // address stable across pc load
  logic accept; // request wins this cycle

  //////////////////////////////////////////////////////////////////////
  // acceptance
  // strictly above current priority
  // priority zero refused outright, whatever the current priority
  assign accept = (state == ive_pkg::IVE_IDLE) && global_irq_enable &&
                  (pending_priority_number != ive_pkg::PRIO_NONE) &&
                  (pending_priority_number > current_cpu_priority);
  assign take_irq = accept;

  // address formed in the accept cycle
  ive_addr_calc u_calc (
    .prio(pending_priority_number),
    .base(vector_table_base),
    .entry_addr(entry_addr)
  );

  //////////////////////////////////////////////////////////////////////
  // base register
  // zero after reset; guarded by init protect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_table_base <= ive_pkg::VTB_RESET;
    end else if (vtb_wr && !init_end_protect) begin
      vector_table_base <= vtb_wdata & ive_pkg::VTB_WRITE_MASK;
    end
  end
  // overlap of base bits 9:7 with shifted priority, for software visibility
  assign base_overlap_warn =
    |(vector_table_base & ive_pkg::VTB_OVERLAP_MASK);

  //////////////////////////////////////////////////////////////////////
  // sequencer: idle, load pc, back to idle
  always_comb begin
    next_state = state;
    case (state)
      ive_pkg::IVE_IDLE: begin
        if (accept) begin
          next_state = ive_pkg::IVE_LOAD;
        end
      end
      ive_pkg::IVE_LOAD: begin
        // hold until the pipeline takes the redirect
        if (pc_ready) begin
          next_state = ive_pkg::IVE_IDLE;
        end
      end
      default: begin
        next_state = ive_pkg::IVE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ive_pkg::IVE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // captured priority and address
  // registered so the target is stable during the load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serviced_priority <= ive_pkg::PRIO_NONE;
      held_addr <= ive_pkg::VTB_RESET;
    end else if (accept) begin
      serviced_priority <= pending_priority_number;
      held_addr <= entry_addr;
    end
  end

  // redirect fetch to the vector entry
  assign pc_load = (state == ive_pkg::IVE_LOAD);
  // slots of eight words ascending with priority
  assign pc_target = held_addr;

  //////////////////////////////////////////////////////////////////////
  // live enable and priority
  // entry beats software writes; return beats software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= ive_pkg::IE_RESET;
      current_cpu_priority <= ive_pkg::CUR_PRIO_RESET;
    end else if (accept) begin
      global_irq_enable <= 1'b0;
      current_cpu_priority <= pending_priority_number;
    end else if (return_from_exception) begin
      global_irq_enable <= saved_irq_enable;
      current_cpu_priority <= saved_cpu_priority;
    end else if (icw_wr) begin
      global_irq_enable <= icw_ie;
      current_cpu_priority <= icw_priority;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // previous context fields
  // saved only on the accept edge, as entry changes the live fields, from their old values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_irq_enable <= ive_pkg::IE_RESET;
      saved_cpu_priority <= ive_pkg::CUR_PRIO_RESET;
    end else if (accept) begin
      saved_irq_enable <= global_irq_enable;
      saved_cpu_priority <= current_cpu_priority;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_entry_addr_form: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |-> entry_addr == (vector_table_base |
      {19'h00000, pending_priority_number, 5'h00}))
    else $error("entry address mismatch");

  a_pc_load_next: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |=> pc_load && pc_target == $past(entry_addr))
    else $error("pc load missing after accept");

  a_slot_spacing: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |=> pc_target[4:0] == $past(vector_table_base[4:0]))
    else $error("entry not on eight word slot");

  a_prio_zero_never: assert property (
    @(posedge clk) disable iff (!rst_n)
    pending_priority_number == 8'h00 |-> !take_irq)
    else $error("priority zero taken");

  a_base_bit_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    !vector_table_base[0])
    else $error("base bit zero set");

  a_base_protect: assert property (
    @(posedge clk) disable iff (!rst_n)
    (vtb_wr && init_end_protect) |=> $stable(vector_table_base))
    else $error("protected base changed");

  a_entry_state: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |=> !global_irq_enable &&
      current_cpu_priority == $past(pending_priority_number))
    else $error("entry did not update priority or enable");

  a_accept_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    take_irq |-> global_irq_enable &&
      pending_priority_number > current_cpu_priority)
    else $error("request accepted at or below current");

  a_return_restore: assert property (
    @(posedge clk) disable iff (!rst_n)
    (return_from_exception && !accept) |=>
      current_cpu_priority == $past(saved_cpu_priority) &&
      global_irq_enable == $past(saved_irq_enable))
    else $error("return did not restore context");

  a_ctx_save: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept |=> saved_cpu_priority == $past(current_cpu_priority) &&
      saved_irq_enable == $past(global_irq_enable))
    else $error("context not saved on entry");

  a_target_stable: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pc_load && !pc_ready) |=> $stable(pc_target))
    else $error("target moved during load");

  c_take: cover property (@(posedge clk) disable iff (!rst_n)
    accept ##1 pc_load ##[1:4] !pc_load);
  c_return: cover property (@(posedge clk) disable iff (!rst_n)
    return_from_exception);
  c_block: cover property (@(posedge clk) disable iff (!rst_n)
    global_irq_enable && pending_priority_number != 8'h00 &&
    pending_priority_number <= current_cpu_priority);
  c_base_wr: cover property (@(posedge clk) disable iff (!rst_n)
    vtb_wr && !init_end_protect);
endmodule

// ### dv/ive_icu_model.sv
// behavioural interrupt control unit holding the winning priority
`timescale 1ns/1ns
module ive_icu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic post,
  input wire logic [7:0] post_prio,
  input wire logic take_irq,
  output logic [7:0] pending_priority_number
);
  ////////////////////////////////////////////////////////////////////////
  // request stays posted until the cpu accepts it or a new post replaces it; acceptance drops it to none
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_priority_number <= 8'h00;
    end else if (take_irq) begin
      pending_priority_number <= 8'h00;
    end else if (post) begin
      pending_priority_number <= post_prio;
    end
  end
endmodule

// ### dv/tb_top.sv
// self-checking testbench for the interrupt entry and exit logic
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst_n = 0, vtb_wr = 0, init_end_protect = 1;
  logic icw_wr = 0, icw_ie = 0, ret_pulse = 0, pc_ready = 0, post = 0;
  logic [7:0] icw_prio = 8'h00, post_prio = 8'h00, pend, cur_prio;
  logic [7:0] sav_prio, sprio;
  logic [31:0] vtb_wdata = 32'h0, eb = 32'h0, last, t1, pc_target, vtb;
  logic take_irq, pc_load, ie, sie, warn;
  int failures = 0, checks_done = 0, cycles = 0;
  always #50 clk = ~clk;
  ive_icu_model icu_u (.clk(clk), .rst_n(rst_n), .post(post),
    .post_prio(post_prio), .take_irq(take_irq),
    .pending_priority_number(pend));
  ive_core dut_u (.clk(clk), .rst_n(rst_n),
    .pending_priority_number(pend), .vtb_wr(vtb_wr),
    .vtb_wdata(vtb_wdata), .init_end_protect(init_end_protect),
    .icw_wr(icw_wr), .icw_ie(icw_ie), .icw_priority(icw_prio),
    .return_from_exception(ret_pulse), .pc_ready(pc_ready),
    .take_irq(take_irq), .pc_load(pc_load), .pc_target(pc_target),
    .vector_table_base(vtb), .global_irq_enable(ie),
    .current_cpu_priority(cur_prio), .saved_cpu_priority(sav_prio),
    .saved_irq_enable(sie), .serviced_priority(sprio),
    .base_overlap_warn(warn));
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // inputs always change one nanosecond after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // each strobe task lets one edge pass first, so a strobe that the
  // previous call just lowered is seen low before it rises again
  task automatic icw(input logic e, input logic [7:0] c);
    step(1);
    icw_ie = e;
    icw_prio = c;
    icw_wr = 1'b1;
    step(1);
    icw_wr = 1'b0;
  endtask
  task automatic post_req(input logic [7:0] p);
    step(1);
    post_prio = p;
    post = 1'b1;
    step(1);
    post = 1'b0;
  endtask
  task automatic base_wr(input logic prot, input logic [31:0] d);
    step(1);
    init_end_protect = prot;
    vtb_wdata = d;
    vtb_wr = 1'b1;
    step(1);
    vtb_wr = 1'b0;
    init_end_protect = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // base writes happen with irqs off, as software must arrange
  task automatic t_base;
    chk(ie, 1'b0);
    base_wr(1'b1, 32'h0000_2000);
    chk(vtb, 32'h0000_0000);
    base_wr(1'b0, 32'h0000_1381);
    chk(vtb, 32'h0000_1380);
    chk(warn, 1'b1);
    eb = 32'h0400_0000;
    base_wr(1'b0, 32'h0400_0001);
    chk(vtb, eb);
    chk(warn, 1'b0);
  endtask
  // take p over current c, stall the redirect, then return
  task automatic t_entry(input logic [7:0] p, input logic [7:0] c);
    icw(1'b1, c);
    post_req(p);
    chk(take_irq, 1'b1);
    step(1);
    last = pc_target;
    chk(last, eb | (32'(p) << ive_pkg::PRIO_SHIFT));
    chk({ie, cur_prio, sprio}, {1'b0, p, p});
    chk({sie, sav_prio}, {1'b1, c});
    step(2);
    chk(pc_load, 1'b1);
    chk(pc_target, last);
    pc_ready = 1'b1;
    step(1);
    pc_ready = 1'b0;
    chk(pc_load, 1'b0);
    ret_pulse = 1'b1;
    step(1);
    ret_pulse = 1'b0;
    chk({ie, cur_prio}, {1'b1, c});
    icw(1'b0, 8'h00);
  endtask
  // equal, zero and disabled requests are refused
  task automatic t_block;
    icw(1'b1, 8'h05);
    post_req(8'h05);
    chk(take_irq, 1'b0);
    post_req(8'h00);
    icw(1'b1, 8'h00);
    chk(take_irq, 1'b0);
    icw(1'b0, 8'h00);
    post_req(8'h03);
    chk(take_irq, 1'b0);
    post_req(8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(5);
    rst_n = 1'b1;
    chk(vtb, 32'h0);
    chk({ie, cur_prio, pc_load}, 32'h0);
    t_base();
    t_block();
    t_entry(8'h01, 8'h00);
    t1 = last;
    t_entry(8'h02, 8'h01);
    chk(last - t1, 32'h20);
    t_entry(8'hff, 8'hfe);
    test_done();
  end
  // hang guard: far above the under sixty cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
endmodule
